/* rtl/lsm_pkg.sv */
// shared constants and types of the limited-speed ramp monitor
package lsm_pkg;
   // ---------------------------------------------------------------
   // register map (byte addresses)
   // ---------------------------------------------------------------
   localparam int unsigned ADDR_W = 8;
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_GRACE = 8'h04;
   localparam logic [7:0] OFF_INDDLY = 8'h08;
   localparam logic [7:0] OFF_RAMPT = 8'h0C;
   localparam logic [7:0] OFF_TRIP = 8'h10;
   localparam logic [7:0] OFF_TARGET = 8'h14;
   localparam logic [7:0] OFF_TOL = 8'h18;
   localparam logic [7:0] OFF_STATUS = 8'h1C;
   localparam logic [7:0] OFF_IRQST = 8'h20;
   localparam logic [7:0] OFF_IRQMSK = 8'h24;
   // ---------------------------------------------------------------
   // fields and reset values
   // ---------------------------------------------------------------
   localparam int CTRL_REQ_BIT = 0;
   localparam int CTRL_MODE_LSB = 1;
   localparam logic [1:0] MODE_DELAY = 2'h0;
   localparam logic [1:0] MODE_MON = 2'h1;
   localparam logic [1:0] MODE_BOTH = 2'h2;
   localparam logic [1:0] MODE_OFF = 2'h3;
   localparam logic [2:0] CTRL_RST = 3'h0;
   localparam logic [15:0] GRACE_MS_RST = 16'h0000;
   localparam logic [15:0] CFG16_RST = 16'h0000;
   localparam logic [3:0] IRQ_RST = 4'h0;
   localparam int IRQ_RAMP = 0;
   localparam int IRQ_LOSS = 1;
   localparam int IRQ_TOFF = 2;
   localparam int IRQ_LIM = 3;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // ---------------------------------------------------------------
   // timing: one millisecond tick from a divider
   // ---------------------------------------------------------------
   localparam int unsigned CLK_HZ = 20_000_000;
   localparam int unsigned TICK_PERIOD_MS = 1;
   localparam int unsigned MS_CYCLES = CLK_HZ / 1000 * TICK_PERIOD_MS;
   localparam int DIV_W = 15;
   localparam logic [15:0] MS_SAT = 16'hFFFF;
   // ---------------------------------------------------------------
   // states and state record
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_RAMP = 3'h1,
      ST_LIM = 3'h3,
      ST_LOSS = 3'h5,
      ST_TOFF = 3'h7
   } lsm_state_t;
   typedef struct packed {
      lsm_state_t st;
      logic awHave;
      logic wHave;
      logic [7:0] awAddr;
      logic [31:0] wData;
      logic [3:0] wStrb;
      logic bValid;
      logic [1:0] bResp;
      logic rValid;
      logic [31:0] rData;
      logic [1:0] rResp;
      logic [2:0] ctrl;
      logic [15:0] grace;
      logic [15:0] indDly;
      logic [15:0] rampCfg;
      logic [15:0] trip;
      logic [15:0] target;
      logic [15:0] tol;
      logic [3:0] irqStat;
      logic [3:0] irqMask;
      logic reqPrev;
      logic [DIV_W-1:0] divCnt;
      logic [15:0] rampT;
      logic [15:0] rampStart;
      logic [15:0] rampTarget;
      logic [15:0] rampTrip;
      logic [15:0] rampTol;
      logic [15:0] rampMs;
      logic [15:0] graceMs;
      logic [15:0] indMs;
      logic [15:0] heldSpeed;
      logic torqueOff;
      logic limActive;
   } lsm_regs_t;
   localparam lsm_regs_t REGS_RST = '0;
endpackage

/* rtl/lsm_ramp_monitor.sv */
// limited-speed ramp monitor with modulation-loss reaction, AXI4-Lite
//
// How it works
// [R1] request above trip limit starts ramp monitoring
// [R2] drive ramps speed down toward limited level
// [R3] zero ramp time selects drive's decel time
// [R4] delay mode: loss stops monitor, starts timers
// [R5] modulation back in time: resume latched ramp
// [R6] midpoint speed: end ramp, limited active on
// [R7] monitor mode: keep monitoring on held speed
// [R8] monitor mode: held speed violates ramp, torque off
// [R9] drive keeps decelerating inside ramp limits
// [R10] monitor mode: indication after indication delay
// [R11] delay mode: grace expiry without modulation, torque off
// [R12] reset: delay mode, grace time zero
// [R13] selector picks one of four loss reactions
// [R14] modulation return cancels running grace timer
`timescale 1ns/1ps
module lsm_ramp_monitor
#(
   parameter int unsigned MS_CYCLES = lsm_pkg::MS_CYCLES
)
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic modPresent,
   input wire logic [15:0] speedEst,
   input wire logic [15:0] driveDecelTime,
   output logic rampMonActive,
   output logic torqueOffOutputFlag,
   output logic limitedSpeedActiveFlag,
   output logic irq
);
   lsm_pkg::lsm_regs_t s_q;
   lsm_pkg::lsm_regs_t s_d;
   logic tick;
   logic reqRise;
   logic [1:0] mode;
   logic monMode;
   logic delayMode;
   logic [15:0] spdUse;
   logic viol;
   logic atMid;
   logic [3:0] ev;
   logic rdClear;

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   function automatic logic [31:0] wmerge(input logic [31:0] old,
                                         input logic [31:0] dat,
                                         input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++)
      begin
         if (strb[i])
         begin
            r[i*8 +: 8] = dat[i*8 +: 8];
         end
      end
      return r;
   endfunction

   function automatic logic [15:0] satInc(input logic [15:0] v);
      return (v == lsm_pkg::MS_SAT) ? v : v + 16'h0001;
   endfunction

   // speed above the linearly falling reference plus tolerance
   function automatic logic rampViol(input logic [15:0] spd,
                                     input logic [15:0] st,
                                     input logic [15:0] tg,
                                     input logic [15:0] tl,
                                     input logic [15:0] t,
                                     input logic [15:0] ms);
      logic [15:0] diff;
      logic [31:0] refv;
      logic [32:0] lim;
      diff = (st > tg) ? st - tg : 16'h0000;
      refv = 32'(st) * 32'(t) - 32'(ms) * 32'(diff);
      lim = {1'b0, refv} + {1'b0, 32'(tl) * 32'(t)};
      return {1'b0, 32'(spd) * 32'(t)} > lim;
   endfunction

   // ---------------------------------------------------------------
   // monitor decisions
   // ---------------------------------------------------------------
   assign tick = (s_q.divCnt == lsm_pkg::DIV_W'(MS_CYCLES - 1));
   assign reqRise = s_q.ctrl[lsm_pkg::CTRL_REQ_BIT] & ~s_q.reqPrev;
   assign mode = s_q.ctrl[lsm_pkg::CTRL_MODE_LSB +: 2];
   assign monMode = (mode == lsm_pkg::MODE_MON) |
                    (mode == lsm_pkg::MODE_BOTH); // [R13]
   assign delayMode = (mode == lsm_pkg::MODE_DELAY) |
                      (mode == lsm_pkg::MODE_BOTH); // [R13]
   assign spdUse = (s_q.st == lsm_pkg::ST_LOSS) ? s_q.heldSpeed
                                                : speedEst; // [R7]
   assign viol = rampViol(spdUse, s_q.rampStart, s_q.rampTarget,
                          s_q.rampTol, s_q.rampT, s_q.rampMs);
   assign atMid = {1'b0, speedEst} <=
                  (({1'b0, s_q.rampTarget} + {1'b0, s_q.rampTrip}) >> 1);
   assign rdClear = s_axi_arvalid & s_axi_arready &
                    (s_axi_araddr == lsm_pkg::OFF_IRQST);

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb
   begin
      s_d = s_q;
      ev = 4'h0;
      s_d.reqPrev = s_q.ctrl[lsm_pkg::CTRL_REQ_BIT];
      s_d.divCnt = tick ? '0 : s_q.divCnt + 1'b1;
      if (modPresent)
      begin
         s_d.heldSpeed = speedEst; // [R7]
      end
      if (tick && s_q.rampMs < s_q.rampT)
      begin
         s_d.rampMs = s_q.rampMs + 16'h0001;
      end
      unique case (s_q.st)
         lsm_pkg::ST_IDLE:
         begin
            if (reqRise)
            begin
               s_d.rampStart = speedEst;
               s_d.rampTarget = s_q.target;
               s_d.rampTrip = s_q.trip;
               s_d.rampTol = s_q.tol;
               s_d.rampT = (s_q.rampCfg == 16'h0000) ? driveDecelTime
                                                     : s_q.rampCfg; // [R3]
               s_d.rampMs = 16'h0000;
               if (speedEst > s_q.trip)
               begin
                  s_d.st = lsm_pkg::ST_RAMP; // [R1]
                  ev[lsm_pkg::IRQ_RAMP] = 1'b1;
               end
               else
               begin
                  s_d.st = lsm_pkg::ST_LIM;
                  s_d.limActive = 1'b1;
                  ev[lsm_pkg::IRQ_LIM] = 1'b1;
               end
            end
         end
         lsm_pkg::ST_RAMP:
         begin
            if (!s_q.ctrl[lsm_pkg::CTRL_REQ_BIT])
            begin
               s_d.st = lsm_pkg::ST_IDLE;
            end
            else if (!modPresent)
            begin
               s_d.st = lsm_pkg::ST_LOSS; // [R4]
               s_d.graceMs = 16'h0000;
               s_d.indMs = 16'h0000;
               ev[lsm_pkg::IRQ_LOSS] = 1'b1;
            end
            else if (viol)
            begin
               s_d.st = lsm_pkg::ST_TOFF;
               s_d.torqueOff = 1'b1;
               ev[lsm_pkg::IRQ_TOFF] = 1'b1;
            end
            else if (atMid)
            begin
               s_d.st = lsm_pkg::ST_LIM; // [R6]
               s_d.limActive = 1'b1;
               ev[lsm_pkg::IRQ_LIM] = 1'b1;
            end
         end
         lsm_pkg::ST_LOSS:
         begin
            if (tick)
            begin
               s_d.graceMs = satInc(s_q.graceMs);
               s_d.indMs = satInc(s_q.indMs);
            end
            if (!s_q.ctrl[lsm_pkg::CTRL_REQ_BIT])
            begin
               s_d.st = lsm_pkg::ST_IDLE;
               s_d.limActive = 1'b0;
               s_d.graceMs = 16'h0000; // [R14]
            end
            else if (modPresent)
            begin
               // latched ramp settings stay in force
               s_d.st = lsm_pkg::ST_RAMP; // [R5] [R9]
               s_d.graceMs = 16'h0000; // [R14]
               s_d.indMs = 16'h0000;
            end
            else if ((delayMode && s_q.graceMs >= s_q.grace) ||
                     (monMode && viol)) // [R8] [R11]
            begin
               s_d.st = lsm_pkg::ST_TOFF;
               s_d.torqueOff = 1'b1;
               ev[lsm_pkg::IRQ_TOFF] = 1'b1;
            end
            else if (s_q.indMs >= s_q.indDly && !s_q.limActive)
            begin
               s_d.limActive = 1'b1; // [R10]
               ev[lsm_pkg::IRQ_LIM] = 1'b1;
            end
         end
         lsm_pkg::ST_LIM, lsm_pkg::ST_TOFF:
         begin
            if (!s_q.ctrl[lsm_pkg::CTRL_REQ_BIT])
            begin
               s_d.st = lsm_pkg::ST_IDLE;
               s_d.limActive = 1'b0;
               s_d.torqueOff = 1'b0;
            end
         end
         default:
         begin
            s_d.st = lsm_pkg::ST_IDLE;
         end
      endcase

      // bus write side
      if (s_axi_awvalid && s_axi_awready)
      begin
         s_d.awHave = 1'b1;
         s_d.awAddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
         s_d.wHave = 1'b1;
         s_d.wData = s_axi_wdata;
         s_d.wStrb = s_axi_wstrb;
      end
      if (s_q.bValid && s_axi_bready)
      begin
         s_d.bValid = 1'b0;
      end
      if (s_q.awHave && s_q.wHave && !s_q.bValid)
      begin
         s_d.awHave = 1'b0;
         s_d.wHave = 1'b0;
         s_d.bValid = 1'b1;
         s_d.bResp = lsm_pkg::RESP_OKAY;
         case (s_q.awAddr)
            lsm_pkg::OFF_CTRL: s_d.ctrl =
               3'(wmerge(32'(s_q.ctrl), s_q.wData, s_q.wStrb));
            lsm_pkg::OFF_GRACE: s_d.grace =
               16'(wmerge(32'(s_q.grace), s_q.wData, s_q.wStrb));
            lsm_pkg::OFF_INDDLY: s_d.indDly =
               16'(wmerge(32'(s_q.indDly), s_q.wData, s_q.wStrb));
            lsm_pkg::OFF_RAMPT: s_d.rampCfg =
               16'(wmerge(32'(s_q.rampCfg), s_q.wData, s_q.wStrb));
            lsm_pkg::OFF_TRIP: s_d.trip =
               16'(wmerge(32'(s_q.trip), s_q.wData, s_q.wStrb));
            lsm_pkg::OFF_TARGET: s_d.target =
               16'(wmerge(32'(s_q.target), s_q.wData, s_q.wStrb));
            lsm_pkg::OFF_TOL: s_d.tol =
               16'(wmerge(32'(s_q.tol), s_q.wData, s_q.wStrb));
            lsm_pkg::OFF_IRQMSK: s_d.irqMask =
               4'(wmerge(32'(s_q.irqMask), s_q.wData, s_q.wStrb));
            lsm_pkg::OFF_STATUS, lsm_pkg::OFF_IRQST: ;
            default: s_d.bResp = lsm_pkg::RESP_SLVERR;
         endcase
      end

      // bus read side
      if (s_q.rValid && s_axi_rready)
      begin
         s_d.rValid = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready)
      begin
         s_d.rValid = 1'b1;
         s_d.rResp = lsm_pkg::RESP_OKAY;
         case (s_axi_araddr)
            lsm_pkg::OFF_CTRL: s_d.rData = 32'(s_q.ctrl);
            lsm_pkg::OFF_GRACE: s_d.rData = 32'(s_q.grace);
            lsm_pkg::OFF_INDDLY: s_d.rData = 32'(s_q.indDly);
            lsm_pkg::OFF_RAMPT: s_d.rData = 32'(s_q.rampCfg);
            lsm_pkg::OFF_TRIP: s_d.rData = 32'(s_q.trip);
            lsm_pkg::OFF_TARGET: s_d.rData = 32'(s_q.target);
            lsm_pkg::OFF_TOL: s_d.rData = 32'(s_q.tol);
            lsm_pkg::OFF_STATUS: s_d.rData = 32'({modPresent,
               s_q.limActive, s_q.torqueOff, rampMonActive, s_q.st});
            lsm_pkg::OFF_IRQST: s_d.rData = 32'(s_q.irqStat);
            lsm_pkg::OFF_IRQMSK: s_d.rData = 32'(s_q.irqMask);
            default:
            begin
               s_d.rData = 32'h0000_0000;
               s_d.rResp = lsm_pkg::RESP_SLVERR;
            end
         endcase
      end
      // new events win over the clearing read
      s_d.irqStat = (rdClear ? lsm_pkg::IRQ_RST : s_q.irqStat) | ev;
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         s_q <= lsm_pkg::REGS_RST; // [R12]
      end
      else
      begin
         s_q <= s_d;
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   assign s_axi_awready = ~s_q.awHave;
   assign s_axi_wready = ~s_q.wHave;
   assign s_axi_bvalid = s_q.bValid;
   assign s_axi_bresp = s_q.bResp;
   assign s_axi_arready = ~s_q.rValid;
   assign s_axi_rvalid = s_q.rValid;
   assign s_axi_rdata = s_q.rData;
   assign s_axi_rresp = s_q.rResp;
   assign rampMonActive = (s_q.st == lsm_pkg::ST_RAMP) |
                          ((s_q.st == lsm_pkg::ST_LOSS) & monMode);
   assign torqueOffOutputFlag = s_q.torqueOff;
   assign limitedSpeedActiveFlag = s_q.limActive;
   assign irq = |(s_q.irqStat & s_q.irqMask);

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   property p_rampStart;
      (s_q.st == lsm_pkg::ST_IDLE && reqRise && speedEst > s_q.trip)
      |=> (s_q.st == lsm_pkg::ST_RAMP) && rampMonActive;
   endproperty
   a_rampStart: assert property (p_rampStart) // [R1]
      else $error("ramp monitoring not started");
   property p_rampTime;
      (s_q.st == lsm_pkg::ST_IDLE && reqRise) |=> s_q.rampT ==
      ($past(s_q.rampCfg) == 16'h0000 ? $past(driveDecelTime)
                                      : $past(s_q.rampCfg));
   endproperty
   a_rampTime: assert property (p_rampTime) // [R3]
      else $error("wrong ramp time latched");
   property p_lossDelay;
      (s_q.st == lsm_pkg::ST_RAMP && !modPresent && mode ==
       lsm_pkg::MODE_DELAY && s_q.ctrl[0]) |=> (s_q.st == lsm_pkg::ST_LOSS)
      && !rampMonActive && s_q.graceMs == 16'h0000 && s_q.indMs == 16'h0000;
   endproperty
   a_lossDelay: assert property (p_lossDelay) // [R4]
      else $error("loss did not start timers");
   property p_resume;
      (s_q.st == lsm_pkg::ST_LOSS && modPresent && s_q.ctrl[0])
      |=> (s_q.st == lsm_pkg::ST_RAMP) && $stable(s_q.rampT) &&
          $stable(s_q.rampStart) && $stable(s_q.rampTol);
   endproperty
   a_resume: assert property (p_resume) // [R5]
      else $error("ramp not resumed with latched settings");
   property p_mid;
      (s_q.st == lsm_pkg::ST_RAMP && modPresent && !viol && atMid &&
       s_q.ctrl[0]) |=> limitedSpeedActiveFlag && !rampMonActive;
   endproperty
   a_mid: assert property (p_mid) // [R6]
      else $error("limited speed not entered at midpoint");
   property p_hold;
      (s_q.st == lsm_pkg::ST_LOSS && !modPresent)
      |=> $stable(s_q.heldSpeed);
   endproperty
   a_hold: assert property (p_hold) // [R7]
      else $error("held speed changed during loss");
   property p_monToff;
      (s_q.st == lsm_pkg::ST_LOSS && monMode && !modPresent && viol &&
       s_q.ctrl[0]) |=> torqueOffOutputFlag [*2];
   endproperty
   a_monToff: assert property (p_monToff) // [R8]
      else $error("no torque off on held speed violation");
   property p_indDelay;
      (s_q.st == lsm_pkg::ST_LOSS && s_q.indMs < s_q.indDly &&
       !s_q.limActive) |=> !limitedSpeedActiveFlag;
   endproperty
   a_indDelay: assert property (p_indDelay) // [R10]
      else $error("indication before delay");
   property p_graceToff;
      (s_q.st == lsm_pkg::ST_LOSS && delayMode && !modPresent &&
       s_q.graceMs >= s_q.grace && s_q.ctrl[0])
      |=> (s_q.st == lsm_pkg::ST_TOFF) && torqueOffOutputFlag;
   endproperty
   a_graceToff: assert property (p_graceToff) // [R11]
      else $error("no torque off at grace expiry");
   property p_resetVals;
      disable iff (1'b0) rst |=> mode == lsm_pkg::MODE_DELAY &&
      s_q.grace == lsm_pkg::GRACE_MS_RST;
   endproperty
   a_resetVals: assert property (p_resetVals) // [R12]
      else $error("wrong reset configuration");
   property p_offMode;
      (s_q.st == lsm_pkg::ST_LOSS && mode == lsm_pkg::MODE_OFF)
      |=> !torqueOffOutputFlag;
   endproperty
   a_offMode: assert property (p_offMode) // [R13]
      else $error("torque off with reactions disabled");
   property p_cancel;
      (s_q.st == lsm_pkg::ST_LOSS && modPresent) |=> s_q.graceMs == 16'h0000;
   endproperty
   a_cancel: assert property (p_cancel) // [R14]
      else $error("grace timer not cancelled");

   c_loss: cover property (s_q.st == lsm_pkg::ST_RAMP ##1
                           s_q.st == lsm_pkg::ST_LOSS);
   c_resume: cover property (s_q.st == lsm_pkg::ST_LOSS ##1
                             s_q.st == lsm_pkg::ST_RAMP);
   c_toff: cover property (s_q.st == lsm_pkg::ST_LOSS ##1
                           s_q.st == lsm_pkg::ST_TOFF);
   c_lim: cover property (s_q.st == lsm_pkg::ST_RAMP ##1
                          s_q.st == lsm_pkg::ST_LIM);
endmodule // lsm_ramp_monitor

/* bench/lsm_drive_model.sv */
// drive control model: modulation status and speed estimate
`timescale 1ns/1ps
module lsm_drive_model
(
   input wire logic clk,
   input wire logic rst,
   input wire logic load,
   input wire logic [15:0] startSpeed,
   input wire logic modOn,
   output logic [15:0] speedEst,
   output logic modPresent,
   output logic [15:0] driveDecelTime
);
   // ----
   // speed profile
   // ----
   logic [15:0] speed_q;
   assign driveDecelTime = 16'h0014;
   assign modPresent = modOn;
   // estimate meaningless while not modulating
   assign speedEst = modOn ? speed_q : ~speed_q;
   always_ff @(posedge clk)
   begin
      if (rst || load)
         speed_q <= rst ? 16'h0000 : startSpeed;
      else if (speed_q > 16'h0258)
         speed_q <= speed_q - (modOn ? 16'h0014 : 16'h0001);
   end
endmodule // lsm_drive_model

/* bench/test_lsm_ramp_monitor.sv */
// self-checking bench of the limited-speed ramp monitor
`timescale 1ns/1ps
module test_lsm_ramp_monitor;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, modPresent, rampMonActive, irq;
   logic torqueOffOutputFlag, limitedSpeedActiveFlag;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [15:0] speedEst, driveDecelTime, startSpeed = 16'h0000;
   logic load = 1'b0, modOn = 1'b1, snap = 1'b0;
   logic [33:0] rdQ[$], bQ[$], outQ[$];
   logic [3:0] outs;
   logic [1:0] md [3] = '{lsm_pkg::MODE_DELAY, lsm_pkg::MODE_BOTH,
      lsm_pkg::MODE_OFF};
   int fail_count = 0, checked = 0, seed = 32'h1c07;
   assign outs = {rampMonActive, torqueOffOutputFlag,
      limitedSpeedActiveFlag, irq};
   lsm_ramp_monitor #(.MS_CYCLES(4)) i_lsm_ramp_monitor (.clk, .rst,
      .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .modPresent, .speedEst, .driveDecelTime,
      .rampMonActive, .torqueOffOutputFlag, .limitedSpeedActiveFlag, .irq);
   lsm_drive_model i_lsm_drive_model (.clk, .rst, .load, .startSpeed,
      .modOn, .speedEst, .modPresent, .driveDecelTime);
   initial
      forever #25 clk = ~clk;
   // ----
   // checking and bus tasks
   // ----
   task automatic final_report();
      if (fail_count == 0 && checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic guard(input bit ok);
      if (!ok)
      begin
         fail_count++;
         final_report();
      end
   endtask
   task automatic cmp_rd(input logic [33:0] got, exp);
      checked++;
      if (got !== exp)
      begin
         fail_count++;
         $display("Error %0t read got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic cmp_resp(input logic [33:0] got, exp);
      checked++;
      if (got !== exp)
      begin
         fail_count++;
         $display("Error %0t bresp got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic cmp_outs(input logic [33:0] got, exp);
      checked++;
      if (got !== exp)
      begin
         fail_count++;
         $display("Error %0t outs got %h exp %h", $time, got, exp);
      end
   endtask
   always @(posedge clk)
   begin
      if (s_axi_rvalid && s_axi_rready)
         cmp_rd({s_axi_rresp, s_axi_rdata}, rdQ.pop_front());
      if (s_axi_bvalid && s_axi_bready)
         cmp_resp({32'h0, s_axi_bresp}, bQ.pop_front());
      if (snap)
         cmp_outs({30'h0, outs}, outQ.pop_front());
   end
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
      input logic [1:0] e);
      bit done = 1'b0;
      bQ.push_back({32'h0, e});
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (int n = 0; n < 50 && !done; n++)
      begin
         @(posedge clk);
         if (s_axi_awready)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wready)
            s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid)
         begin
            s_axi_bready <= 1'b0;
            done = 1'b1;
         end
      end
      guard(done);
      @(posedge clk);
   endtask
   task automatic rd(input logic [7:0] a, input logic [33:0] e);
      bit done = 1'b0;
      rdQ.push_back(e);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (int n = 0; n < 50 && !done; n++)
      begin
         @(posedge clk);
         if (s_axi_arready)
            s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid)
         begin
            s_axi_rready <= 1'b0;
            done = 1'b1;
         end
      end
      guard(done);
      @(posedge clk);
   endtask
   task automatic chk(input logic [3:0] e);
      outQ.push_back({30'h0, e});
      snap <= 1'b1;
      @(posedge clk);
      snap <= 1'b0;
      @(posedge clk);
   endtask
   task automatic wait_st(input logic [3:0] m, v, input int n);
      while (n > 0 && (outs & m) !== v)
      begin
         @(posedge clk);
         n--;
      end
      guard((outs & m) === v);
   endtask
   task automatic arm(input logic [1:0] m);
      startSpeed <= 16'h07D0 + 16'($random(seed) & 63);
      load <= 1'b1;
      modOn <= 1'b1;
      @(posedge clk);
      load <= 1'b0;
      wr(lsm_pkg::OFF_CTRL, {29'h0, m, 1'b1}, lsm_pkg::RESP_OKAY);
      wait_st(4'h8, 4'h8, 10);
      modOn <= 1'b0;
   endtask
   task automatic disarm(input logic [31:0] st);
      rd(lsm_pkg::OFF_IRQST, {2'h0, st});
      wr(lsm_pkg::OFF_CTRL, 32'h0, lsm_pkg::RESP_OKAY);
      chk(4'h0);
   endtask
   // ----
   // scenarios
   // ----
   initial
   begin
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      rd(lsm_pkg::OFF_CTRL, 34'h0);
      rd(lsm_pkg::OFF_GRACE, 34'h0);
      rd(8'h40, {lsm_pkg::RESP_SLVERR, 32'h0});
      wr(8'h40, $random(seed), lsm_pkg::RESP_SLVERR);
      wr(lsm_pkg::OFF_IRQMSK, 32'h4, lsm_pkg::RESP_OKAY);
      wr(lsm_pkg::OFF_TRIP, 32'h3E8, lsm_pkg::RESP_OKAY);
      wr(lsm_pkg::OFF_TARGET, 32'h258, lsm_pkg::RESP_OKAY);
      wr(lsm_pkg::OFF_TOL, 32'h190, lsm_pkg::RESP_OKAY);
      wr(lsm_pkg::OFF_RAMPT, 32'h14, lsm_pkg::RESP_OKAY);
      // zero grace: loss trips at once in delay and both modes, not with the reaction off
      for (int i = 0; i < 3; i++)
      begin
         arm(md[i]);
         repeat (4) @(posedge clk);
         chk(i < 2 ? 4'h5 : 4'h2);
         disarm(i < 2 ? 32'h7 : 32'hB);
      end
      // loss shorter than grace, drive ramp used
      wr(lsm_pkg::OFF_GRACE, 32'hA, lsm_pkg::RESP_OKAY);
      wr(lsm_pkg::OFF_INDDLY, 32'h64, lsm_pkg::RESP_OKAY);
      wr(lsm_pkg::OFF_RAMPT, 32'h0, lsm_pkg::RESP_OKAY);
      arm(lsm_pkg::MODE_DELAY);
      repeat (3) @(posedge clk);
      chk(4'h0);
      repeat (8) @(posedge clk);
      modOn <= 1'b1;
      repeat (2) @(posedge clk);
      chk(4'h8);
      wait_st(4'hE, 4'h2, 200);
      disarm(32'hB);
      // held speed falls out of the ramp
      wr(lsm_pkg::OFF_INDDLY, 32'h2, lsm_pkg::RESP_OKAY);
      wr(lsm_pkg::OFF_RAMPT, 32'h14, lsm_pkg::RESP_OKAY);
      arm(lsm_pkg::MODE_MON);
      repeat (2) @(posedge clk);
      chk(4'h8);
      wait_st(4'h2, 4'h2, 40);
      chk(4'hA);
      wait_st(4'h4, 4'h4, 150);
      disarm(32'hF);
      final_report();
   end
endmodule // test_lsm_ramp_monitor
